// ==== bitp_pkg.sv ====
// constants and types of the interval timer with clock prescaler
// Functional notes
// R1 - oscillator input halved before internal use (the rc options here take every oscillator edge unhalved)
// R2 - peripheral clocks: undivided plus divide 2..4096
// R3 - stop gates peripheral clock, leaving restores it
// R4 - rc option drives oscillator output at f/4
// R5 - clock source follows nonvolatile option code
// R6 - 8-bit counter runs freely, no halt
// R7 - counter steps once per prescaler pulse
// R8 - wrap from ff to 00 sets overflow flag
// R9 - rc select moves counter to rc clock
// R10 - clear bit zeroes counter, self-clears next cycle
// R11 - stop with rc select keeps timer alive
// R12 - low three bits pick divide 8..1024
// R13 - one address: read count, write control
// R14 - software avoids bit ops on control
// R15 - timer pulses advance the watchdog counter
// R16 - control bit picks watchdog or plain timer
// R17 - watchdog mode select sits at bit 4
// R18 - reset clears counter and all control bits
// R19 - flag sticks until acknowledged, gated by enable
package bitp_pkg;
    // byte address shared by count (read) and control (write)
    localparam logic [7:0] BITP_ADDR_COUNT = 8'hec;
    // own registers for interrupt status, mask and stop control
    localparam logic [7:0] BITP_ADDR_STATUS = 8'hf0;
    localparam logic [7:0] BITP_ADDR_MASK = 8'hf4;
    localparam logic [7:0] BITP_ADDR_SYSCTL = 8'hf8;
    // control field positions
    localparam int BITP_SEL_LSB = 0;
    localparam int BITP_CLR_BIT = 3;
    localparam int BITP_WDT_BIT = 4;
    localparam int BITP_RC_BIT = 5;
    // values after reset
    localparam logic [7:0] BITP_CTRL_RST = 8'h00;
    localparam logic [7:0] BITP_COUNT_RST = 8'h00;
    // prescaler chain length: taps up to divide by 4096
    localparam int BITP_DIV_BITS = 12;
    // fixed offset of select code onto tap: code 0 is divide by 8
    localparam int BITP_SEL_BASE = 3;
    // rc option output divisor as a counter width (f/4)
    localparam int BITP_RCOUT_BITS = 2;
    // nonvolatile clock option codes
    typedef enum logic [2:0] {
        BITP_OPT_XTAL = 3'b000,
        BITP_OPT_EXT_RC = 3'b001,
        BITP_OPT_EXT_RC_CLKOUT = 3'b010,
        BITP_OPT_INT_FAST = 3'b011,
        BITP_OPT_INT_SLOW = 3'b100,
        BITP_OPT_INT_FAST_CLKOUT = 3'b101,
        BITP_OPT_INT_SLOW_CLKOUT = 3'b110
    } bitp_opt_type;
    // bit of the status register
    localparam int BITP_ST_OVF = 0;
endpackage

// ==== bitp_prescaler.sv ====
// prescaler chain producing one-cycle divided enables
`timescale 1ns/1ps
module bitp_prescaler #(
    parameter int DIV_BITS = bitp_pkg::BITP_DIV_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_tick,
    input wire logic run,
    output logic [DIV_BITS:0] tick
);
    // binary counter of source ticks, stepped on pclk
    logic [DIV_BITS-1:0] cnt_q;
    logic [DIV_BITS-1:0] cnt_d;
    assign cnt_d = cnt_q + {{(DIV_BITS-1){1'b0}}, 1'b1};

    // advance only on a live source tick while not stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (src_tick && run) begin
            cnt_q <= cnt_d;
        end
    end

    // tap k pulses once every 2**k source ticks; tap 0 is undivided
    assign tick[0] = src_tick && run; // R2 R3
    genvar k;
    generate
        for (k = 1; k <= DIV_BITS; k++) begin : g_tap
            assign tick[k] = src_tick && run && (cnt_q[k-1:0] == {k{1'b1}}); // R2
        end
    endgenerate
endmodule

// ==== bitp_timer.sv ====
// interval timer, prescaler control and clock option logic with apb slave
`timescale 1ns/1ps
module bitp_timer #(
    parameter int DIV_BITS = bitp_pkg::BITP_DIV_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_in,
    input wire logic rc_tick,
    input wire logic [2:0] clk_option,
    input wire logic irq_ack,
    output logic irq,
    output logic [DIV_BITS:0] periph_tick,
    output logic wdt_tick,
    output logic watchdog_mode_select,
    output logic rc_watchdog_select,
    output logic stopped,
    output logic osc_out,
    output logic osc_out_en
);
    // option decode
    logic opt_rc;
    logic opt_clkout;
    assign opt_rc = (clk_option == bitp_pkg::BITP_OPT_EXT_RC)
        || (clk_option == bitp_pkg::BITP_OPT_EXT_RC_CLKOUT); // R5
    assign opt_clkout = (clk_option == bitp_pkg::BITP_OPT_EXT_RC_CLKOUT)
        || (clk_option == bitp_pkg::BITP_OPT_INT_FAST_CLKOUT)
        || (clk_option == bitp_pkg::BITP_OPT_INT_SLOW_CLKOUT); // R5

    // halving flip-flop: osc_in is sampled, each rising edge toggles it
    logic osc_last_q;
    logic half_q;
    logic osc_rise;
    assign osc_rise = osc_in && !osc_last_q;
    // crystal path halves; rc path uses the raw oscillator edge
    logic src_tick;
    assign src_tick = opt_rc ? osc_rise : (osc_rise && half_q); // R1 R5

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_last_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            osc_last_q <= osc_in;
            if (osc_rise) begin
                half_q <= !half_q; // R1
            end
        end
    end

    // registers
    logic [7:0] ctrl_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic stop_q;
    logic status_q;
    logic mask_q;

    // apb decode; slave answers in the access cycle with no wait
    logic wr_en;
    logic rd_en;
    logic hit_count;
    logic hit_status;
    logic hit_mask;
    logic hit_sysctl;
    logic hit_any;
    assign pready = 1'b1;
    assign hit_count = (paddr == bitp_pkg::BITP_ADDR_COUNT);
    assign hit_status = (paddr == bitp_pkg::BITP_ADDR_STATUS);
    assign hit_mask = (paddr == bitp_pkg::BITP_ADDR_MASK);
    assign hit_sysctl = (paddr == bitp_pkg::BITP_ADDR_SYSCTL);
    assign hit_any = hit_count || hit_status || hit_mask || hit_sysctl;
    assign wr_en = psel && penable && pwrite && pstrb[0] && hit_any;
    // reads are served from the setup phase so that prdata is settled in access
    assign rd_en = psel && !penable && !pwrite;
    // unmapped addresses answer with an error, no effect
    assign pslverr = psel && penable && !hit_any;

    // stop holds the peripheral clock; rc mode keeps only the timer alive
    logic rc_sel;
    logic periph_run;
    assign rc_sel = ctrl_q[bitp_pkg::BITP_RC_BIT];
    assign periph_run = !stop_q; // R3 R11
    bitp_prescaler #(
        .DIV_BITS(DIV_BITS)
    ) u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .run(periph_run),
        .tick(periph_tick)
    );

    // select code 0 -> tap 3 (divide 8) .. code 7 -> tap 10 (divide 1024)
    logic [3:0] tap_idx;
    logic pre_pulse;
    logic count_pulse;
    assign tap_idx = 4'(ctrl_q[2:0]) + 4'(bitp_pkg::BITP_SEL_BASE); // R12
    assign pre_pulse = periph_tick[tap_idx]; // R7 R12
    // rc select swaps the counter onto the rc oscillator; runs through stop
    assign count_pulse = rc_sel ? rc_tick : pre_pulse; // R9 R11
    logic clr_req;
    assign clr_req = ctrl_q[bitp_pkg::BITP_CLR_BIT];
    logic wrap;
    assign wrap = count_pulse && !clr_req && (count_q == 8'hff); // R8
    assign count_d = clr_req ? bitp_pkg::BITP_COUNT_RST : count_q + 8'h01;

    // counter: free running, no halt bit exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= bitp_pkg::BITP_COUNT_RST; // R18
        end else if (clr_req || count_pulse) begin
            count_q <= count_d; // R6 R7 R10
        end
    end

    // control write; clear bit lives one cycle then drops by hardware
    logic ctrl_wr;
    assign ctrl_wr = wr_en && hit_count; // R13
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= bitp_pkg::BITP_CTRL_RST; // R18
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[7:0];
        end else begin
            ctrl_q[bitp_pkg::BITP_CLR_BIT] <= 1'b0; // R10
        end
    end

    // stop control: written by the core's stop sequence, cleared to leave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_q <= 1'b0;
        end else if (wr_en && hit_sysctl) begin
            stop_q <= pwdata[0]; // R3
        end
    end

    // sticky overflow flag: set wins over ack and write-one clear
    logic ovf_clr;
    assign ovf_clr = irq_ack || (wr_en && hit_status && pwdata[bitp_pkg::BITP_ST_OVF]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            if (wrap) begin
                status_q <= 1'b1; // R8 R19
            end else if (ovf_clr) begin
                status_q <= 1'b0; // R19
            end
            if (wr_en && hit_mask) begin
                mask_q <= pwdata[bitp_pkg::BITP_ST_OVF];
            end
        end
    end
    assign irq = status_q && mask_q; // R19

    // read data: the shared address returns the count, never control
    logic [31:0] rd_mux;
    assign rd_mux = hit_count ? {24'h0, count_q} : // R13
        hit_status ? {31'h0, status_q} :
        hit_mask ? {31'h0, mask_q} :
        hit_sysctl ? {31'h0, stop_q} : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= rd_mux; // captured in setup, stable through access
        end
    end

    // watchdog advance pulse registered from each counter step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_tick <= 1'b0;
        end else begin
            wdt_tick <= count_pulse && !clr_req; // R15
        end
    end
    assign watchdog_mode_select = ctrl_q[bitp_pkg::BITP_WDT_BIT]; // R16 R17
    assign rc_watchdog_select = rc_sel;
    assign stopped = stop_q;

    // clock output at oscillator / 4 in the rc-with-output option
    logic [bitp_pkg::BITP_RCOUT_BITS-1:0] out_div_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_div_q <= '0;
            osc_out <= 1'b0;
        end else begin
            if (osc_rise) begin
                out_div_q <= out_div_q + 2'b01;
            end
            osc_out <= out_div_q[bitp_pkg::BITP_RCOUT_BITS-1]; // R4
        end
    end
    assign osc_out_en = opt_rc && opt_clkout; // R4 R5

    // checks below all run on pclk and are muted while reset is low
    // those on registered state look one edge after the cause, since
    // every register here updates on the edge that samples its cause
    // count bumps by one per pulse absent clear
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (count_pulse && !clr_req) |=> (count_q == $past(count_q) + 8'h01))
        else $error("count did not step");
    // clear bit lives one cycle, then count is zero and the bit has dropped
    a_clear_bit: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (ctrl_wr && pwdata[bitp_pkg::BITP_CLR_BIT]) |=> clr_req ##1
        ((count_q == 8'h00) && (!clr_req || $past(ctrl_wr))))
        else $error("clear bit misbehaved");
    // wrap sets the flag next cycle
    a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn) // R8
        wrap |=> status_q)
        else $error("overflow flag missing");
    // irq only while flag and enable
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // R19
        irq == (status_q && mask_q))
        else $error("irq gating wrong");
    // flag holds absent clear
    a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // R19
        (status_q && !ovf_clr) |=> status_q)
        else $error("flag dropped");
    // no peripheral tick while stopped
    a_stop_gate: assert property (@(posedge pclk) disable iff (!presetn) // R3
        stop_q |-> (periph_tick == '0))
        else $error("tick in stop");
    // rc select counts rc ticks even in stop
    a_rc_count: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (rc_sel && rc_tick && !clr_req && stop_q) |=> count_q != $past(count_q))
        else $error("rc count stalled");
    // read of shared address returns the count
    a_read_count: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (rd_en && hit_count) |=> prdata[7:0] == $past(count_q))
        else $error("read not count");
    // watchdog pulse follows counter step
    a_wdt_tick: assert property (@(posedge pclk) disable iff (!presetn) // R15
        (count_pulse && !clr_req) |=> wdt_tick)
        else $error("watchdog pulse missing");
    // rc option takes every oscillator edge as a source tick
    a_src_rc: assert property (@(posedge pclk) disable iff (!presetn) // R5
        opt_rc |-> (src_tick == osc_rise))
        else $error("rc source wrong");
    // other options pass only every second edge
    a_src_half: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (!opt_rc && osc_rise) |-> (src_tick == half_q))
        else $error("halved source wrong");
    // halving flip-flop toggles on each oscillator edge
    a_half_toggle: assert property (@(posedge pclk) disable iff (!presetn) // R1
        osc_rise |=> (half_q != $past(half_q)))
        else $error("halving stalled");
    // undivided tap follows the source while running
    a_tick_base: assert property (@(posedge pclk) disable iff (!presetn) // R2
        (src_tick && !stop_q) |-> periph_tick[0])
        else $error("undivided tick missing");
    // clear request forces zero on the next edge
    a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn) // R10
        clr_req |=> (count_q == 8'h00))
        else $error("clear ignored");
    // clear bit drops by itself unless rewritten
    a_clear_drop: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (clr_req && !ctrl_wr) |=> !clr_req)
        else $error("clear bit stuck");
    // wrap lands on zero
    a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn) // R8
        wrap |=> (count_q == 8'h00))
        else $error("wrap not zero");
    // count moves only on a pulse or a clear
    a_count_hold: assert property (@(posedge pclk) disable iff (!presetn) // R6
        (!count_pulse && !clr_req) |=> $stable(count_q))
        else $error("count moved");
    // stop without rc select freezes the count
    a_stop_frozen: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (stop_q && !rc_sel && !clr_req) |=> $stable(count_q))
        else $error("count ran in stop");
    // mode bits take the written value
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn) // R17
        ctrl_wr |=> (ctrl_q[7:4] == $past(pwdata[7:4])))
        else $error("mode bits not written");
    // select code takes the written value
    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn) // R12
        ctrl_wr |=> (ctrl_q[2:0] == $past(pwdata[2:0])))
        else $error("select not written");
    // a write without lane zero changes nothing
    a_strobe_refuse: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (psel && penable && pwrite && !pstrb[0]) |=> ($stable(ctrl_q[7:4])
        && $stable(ctrl_q[2:0]) && $stable(stop_q) && $stable(mask_q)))
        else $error("masked write took effect");
    // a write to an unmapped address changes nothing
    a_unmapped_none: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (psel && penable && pwrite && !hit_any) |=> ($stable(ctrl_q[7:4])
        && $stable(stop_q) && $stable(mask_q)))
        else $error("unmapped write took effect");
    // clear without a new wrap empties the flag
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // R19
        (ovf_clr && !wrap) |=> !status_q)
        else $error("flag not cleared");
    // only a wrap raises the flag
    a_flag_source: assert property (@(posedge pclk) disable iff (!presetn) // R8
        (!status_q && !wrap) |=> !status_q)
        else $error("flag rose without wrap");
    // interrupt enable takes the written value
    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn) // R19
        (wr_en && hit_mask) |=> (mask_q == $past(pwdata[0])))
        else $error("enable not written");
    // stop bit takes the written value
    a_stop_write: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (wr_en && hit_sysctl) |=> (stop_q == $past(pwdata[0])))
        else $error("stop not written");
    // no watchdog pulse without a counter step
    a_wdt_source: assert property (@(posedge pclk) disable iff (!presetn) // R15
        !(count_pulse && !clr_req) |=> !wdt_tick)
        else $error("stray watchdog pulse");
    // clock output drives only in the rc-with-output option
    a_out_enable: assert property (@(posedge pclk) disable iff (!presetn) // R4
        osc_out_en |-> (clk_option == bitp_pkg::BITP_OPT_EXT_RC_CLKOUT))
        else $error("clock output in wrong option");
    // clock output is the top bit of the edge counter
    a_out_follow: assert property (@(posedge pclk) disable iff (!presetn) // R4
        osc_out == $past(out_div_q[bitp_pkg::BITP_RCOUT_BITS-1]))
        else $error("clock output wrong");
    // rc select steps the count on each rc tick
    a_rc_path: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (rc_sel && rc_tick && !clr_req) |=> (count_q == $past(count_q) + 8'h01))
        else $error("rc tick not counted");
    // without rc select the rc tick is ignored
    a_sys_path: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (!rc_sel && rc_tick && !pre_pulse && !clr_req) |=> $stable(count_q))
        else $error("rc tick counted");
endmodule

// ==== test_basic_interval_timer_prescaler.sv ====
// self-checking bench of the interval timer and prescaler
`timescale 1ns/1ps
module test_basic_interval_timer_prescaler;
    localparam logic [7:0] A_CNT = bitp_pkg::BITP_ADDR_COUNT;
    localparam logic [7:0] A_ST = bitp_pkg::BITP_ADDR_STATUS;
    localparam logic [7:0] A_MSK = bitp_pkg::BITP_ADDR_MASK;
    localparam logic [7:0] A_SYS = bitp_pkg::BITP_ADDR_SYSCTL;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic osc_in = 1'b0;
    logic rc_tick = 1'b0;
    logic [2:0] clk_option = 3'h0;
    logic irq_ack = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, wdt_tick, wms, rcs, stopped, osc_out, oen;
    logic [12:0] periph_tick;
    logic [31:0] rd; // data of the last read
    logic err; // error flag of the last access
    int error_cnt = 0;
    int compares = 0;
    int seed = 57627;
    int p0_cnt = 0; // undivided tick pulses seen
    int wdt_cnt = 0; // watchdog step pulses seen
    int out_cnt = 0; // clock output rising edges seen
    logic out_last = 1'b0; // level of the clock output at the previous edge
    int m_count = 0; // model of the interval count
    int n;
    // 50 MHz bus clock
    always #10 pclk = ~pclk;
    bitp_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
        .rc_tick(rc_tick), .clk_option(clk_option), .irq_ack(irq_ack), .irq(irq),
        .periph_tick(periph_tick), .wdt_tick(wdt_tick), .watchdog_mode_select(wms),
        .rc_watchdog_select(rcs), .stopped(stopped), .osc_out(osc_out),
        .osc_out_en(oen));
    // pulse counters; the bench zeroes them between tests
    always @(posedge pclk) begin
        if (periph_tick[0] === 1'b1) begin
            p0_cnt <= p0_cnt + 1;
        end
        if (wdt_tick === 1'b1) begin
            wdt_cnt <= wdt_cnt + 1;
        end
        if (osc_out === 1'b1 && out_last === 1'b0) begin
            out_cnt <= out_cnt + 1;
        end
        out_last <= osc_out;
    end
    task final_report();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // prescaler phase after reset is not pinned, so allow one step either way
    task near(input string what, input int exp, input logic [31:0] got);
        compares++;
        if (^got === 1'bx || int'(got) > exp + 1 || int'(got) + 1 < exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // one apb transfer; an idle edge follows so strobes never toggle twice
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // oscillator rising edges, each four bus cycles apart
    task osc(input int rises);
        repeat (rises) begin
            osc_in <= 1'b1;
            repeat (2) @(posedge pclk);
            osc_in <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
    // rc oscillator pulses; the model steps with them
    task rc(input int k);
        repeat (k) begin
            rc_tick <= 1'b1;
            @(posedge pclk);
            rc_tick <= 1'b0;
            @(posedge pclk);
        end
        m_count = (m_count + k) % 256;
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, A_CNT, 32'h0);
        chk("count", 32'h0, rd);
        apb(1'b0, A_ST, 32'h0);
        chk("status", 32'h0, rd);
        chk("mode bits", 32'h0, {30'h0, wms, rcs});
        $display("test reset done");
        for (int o = 0; o < 7; o++) begin
            clk_option <= o[2:0];
            repeat (2) @(posedge pclk);
            chk("clkout enable", 32'(o == 2), 32'(oen));
        end
        // rc option: every oscillator edge is a source tick
        clk_option <= 3'h2;
        p0_cnt = 0;
        out_cnt = 0;
        osc(32);
        near("rc source ticks", 32, 32'(p0_cnt));
        near("clock output", 8, 32'(out_cnt));
        clk_option <= 3'h0;
        $display("test clock options done");
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, A_CNT, 32'(8 + s));
            p0_cnt = 0;
            osc(8 << (s + 3));
            apb(1'b0, A_CNT, 32'h0);
            near("count", 4, rd);
            near("undivided ticks", 4 << (s + 3), 32'(p0_cnt));
        end
        n = int'(rd);
        apb(1'b1, A_CNT, 32'h7);
        apb(1'b0, A_CNT, 32'h0);
        chk("count kept", 32'(n), rd);
        $display("test prescaler done");
        apb(1'b1, A_CNT, 32'h38);
        m_count = 0;
        chk("mode bits", 32'h3, {30'h0, wms, rcs});
        apb(1'b1, A_MSK, 32'h1);
        wdt_cnt = 0;
        n = 1 + ($unsigned($random(seed)) % 200);
        rc(n);
        apb(1'b0, A_CNT, 32'h0);
        chk("rc count", 32'(m_count), rd);
        chk("wdt steps", 32'(n), 32'(wdt_cnt));
        chk("irq", 32'h0, 32'(irq));
        rc(256 - n);
        apb(1'b0, A_ST, 32'h0);
        chk("overflow flag", 32'h1, rd);
        apb(1'b0, A_CNT, 32'h0);
        chk("wrapped count", 32'(m_count), rd);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, A_MSK, 32'h0);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, A_MSK, 32'h1);
        chk("irq unmasked", 32'h1, 32'(irq));
        apb(1'b1, A_ST, 32'h1);
        chk("irq cleared", 32'h0, 32'(irq));
        rc(256);
        chk("irq again", 32'h1, 32'(irq));
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("irq acked", 32'h0, 32'(irq));
        $display("test overflow done");
        apb(1'b1, A_SYS, 32'h1);
        chk("stopped", 32'h1, 32'(stopped));
        rc(10);
        apb(1'b0, A_CNT, 32'h0);
        chk("count in stop", 32'(m_count), rd);
        apb(1'b1, A_CNT, 32'h8);
        p0_cnt = 0;
        osc(64);
        chk("ticks in stop", 32'h0, 32'(p0_cnt));
        apb(1'b0, A_CNT, 32'h0);
        chk("halted count", 32'h0, rd);
        apb(1'b1, A_SYS, 32'h0);
        p0_cnt = 0;
        osc(64);
        near("ticks after stop", 32, 32'(p0_cnt));
        $display("test stop done");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b0, A_CNT, 32'h0);
        chk("mapped error", 32'h0, 32'(err));
        pstrb <= 4'h0;
        apb(1'b1, A_CNT, 32'h20);
        pstrb <= 4'hf;
        chk("rc select", 32'h0, 32'(rcs));
        $display("test refusals done");
        final_report();
    end
endmodule
